// file: verilog/nco_core.sv
// module: numerically controlled oscillator with byte register port
`timescale 1ns/1ps
module nco_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire nco_pkg::nco_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic internal_fast_oscillator,
  input wire logic logic_cell_one_output,
  input wire logic logic_cell_two_output,
  input wire logic logic_cell_three_output,
  input wire logic logic_cell_four_output,
  output logic osc_out,
  output logic overflow_irq_flag
);

  //**********************************************************************
  // registers
  //**********************************************************************
  logic osc_enable_r, output_invert_r, pulse_frequency_select_r;
  logic [2:0] pulse_width_select_r;
  logic [2:0] input_clock_select_r;
  logic [nco_pkg::ACC_W-1:0] phase_accumulator_r;
  logic [7:0] inc_lo_r, inc_hi_r, inc_up_r;
  logic [nco_pkg::ACC_W-1:0] increment_buffer_r;
  logic load_pending_r;
  logic raw_r;
  logic [7:0] pulse_cnt_r;
  logic flag_r;
  logic src_prev_r;
  logic [7:0] rdata_r;
  logic out_r;

  logic wr_ctrl, wr_clk, wr_alo, wr_ahi, wr_aup, wr_ilo, wr_ihi, wr_iup, wr_flag;
  logic src_now, rise_tick, fall_tick;
  logic [nco_pkg::ACC_W:0] sum;
  logic accumulator_carry;
  logic [nco_pkg::ACC_W-1:0] increment_value;
  logic acc_wr;
  logic [7:0] pw_last;
  logic flag_clr;

  assign wr_ctrl = bus_req.wr && bus_req.addr == nco_pkg::OFF_CTRL;
  assign wr_clk = bus_req.wr && bus_req.addr == nco_pkg::OFF_CLKSEL;
  assign wr_alo = bus_req.wr && bus_req.addr == nco_pkg::OFF_ACC_LO;
  assign wr_ahi = bus_req.wr && bus_req.addr == nco_pkg::OFF_ACC_HI;
  assign wr_aup = bus_req.wr && bus_req.addr == nco_pkg::OFF_ACC_UP;
  assign wr_ilo = bus_req.wr && bus_req.addr == nco_pkg::OFF_INC_LO;
  assign wr_ihi = bus_req.wr && bus_req.addr == nco_pkg::OFF_INC_HI;
  assign wr_iup = bus_req.wr && bus_req.addr == nco_pkg::OFF_INC_UP;
  assign wr_flag = bus_req.wr && bus_req.addr == nco_pkg::OFF_FLAG;
  assign acc_wr = wr_alo || wr_ahi || wr_aup;
  assign flag_clr = wr_flag && !bus_req.wdata[nco_pkg::FLAG_BIT];

  //**********************************************************************
  // input clock selection and edge ticks
  //**********************************************************************
  always_comb begin
    unique case (nco_pkg::nco_cksel_t'(input_clock_select_r))
      nco_pkg::NCO_CK_SYS: src_now = 1'b0;
      nco_pkg::NCO_CK_FAST: src_now = internal_fast_oscillator;
      nco_pkg::NCO_CK_LC1: src_now = logic_cell_one_output;
      nco_pkg::NCO_CK_LC2: src_now = logic_cell_two_output;
      nco_pkg::NCO_CK_LC3: src_now = logic_cell_three_output;
      nco_pkg::NCO_CK_LC4: src_now = logic_cell_four_output;
      default: src_now = 1'b0;
    endcase
  end

  // system clock source ticks every cycle; reserved codes never give a rising tick
  always_comb begin
    rise_tick = src_now && !src_prev_r;
    fall_tick = !src_now && src_prev_r;
    if (input_clock_select_r == nco_pkg::NCO_CK_SYS) begin
      rise_tick = 1'b1;
      fall_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_now;
    end
  end

  //**********************************************************************
  // adder and overflow
  //**********************************************************************
  assign sum = {1'b0, phase_accumulator_r} + {1'b0, increment_buffer_r};
  assign accumulator_carry = osc_enable_r && rise_tick && sum[nco_pkg::ACC_W];
  assign increment_value = {inc_up_r[3:0], inc_hi_r, inc_lo_r};
  assign pw_last = 8'((9'(nco_pkg::PW_ONE) << pulse_width_select_r) - 9'h001);

  //**********************************************************************
  // control registers
  //**********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_enable_r <= 1'b0;
      output_invert_r <= 1'b0;
      pulse_frequency_select_r <= 1'b0;
      pulse_width_select_r <= 3'h0;
      input_clock_select_r <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        osc_enable_r <= bus_req.wdata[nco_pkg::CTRL_EN];
        output_invert_r <= bus_req.wdata[nco_pkg::CTRL_POL];
        pulse_frequency_select_r <= bus_req.wdata[nco_pkg::CTRL_PFM];
      end
      if (wr_clk) begin
        pulse_width_select_r <= bus_req.wdata[nco_pkg::PWS_LSB+:3];
        input_clock_select_r <= bus_req.wdata[nco_pkg::CKS_LSB+:3];
      end
    end
  end

  //**********************************************************************
  // increment bytes and buffer
  //**********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inc_lo_r <= nco_pkg::INC_LO_RST;
      inc_hi_r <= nco_pkg::BYTE_RST;
      inc_up_r <= nco_pkg::BYTE_RST;
    end else begin
      if (wr_ilo) inc_lo_r <= bus_req.wdata;
      if (wr_ihi) inc_hi_r <= bus_req.wdata;
      if (wr_iup) inc_up_r <= bus_req.wdata & nco_pkg::UP_MASK;
    end
  end

  // while stopped the buffer follows a low-byte write at once, there is no input edge to wait for
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      increment_buffer_r <= nco_pkg::INCREMENT_BUFFER_RST;
      load_pending_r <= 1'b0;
    end else begin
      if (!osc_enable_r && load_pending_r) begin
        increment_buffer_r <= increment_value;
        load_pending_r <= 1'b0;
      end else if (load_pending_r && fall_tick) begin
        increment_buffer_r <= increment_value;
        load_pending_r <= 1'b0;
      end
      if (wr_ilo) load_pending_r <= 1'b1;
    end
  end

  //**********************************************************************
  // accumulator
  //**********************************************************************
  // a bus write while running races the adder; the bus write wins here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_accumulator_r <= nco_pkg::ACC_RST;
    end else if (acc_wr) begin
      if (wr_alo) phase_accumulator_r[7:0] <= bus_req.wdata;
      if (wr_ahi) phase_accumulator_r[15:8] <= bus_req.wdata;
      if (wr_aup) phase_accumulator_r[19:16] <= bus_req.wdata[3:0];
    end else if (osc_enable_r && rise_tick) begin
      phase_accumulator_r <= sum[nco_pkg::ACC_W-1:0];
    end
  end

  //**********************************************************************
  // output shaping
  //**********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
    end else if (!osc_enable_r) begin
      raw_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
    end else if (!pulse_frequency_select_r) begin
      if (accumulator_carry) raw_r <= !raw_r;
    end else if (accumulator_carry) begin
      raw_r <= 1'b1;
      pulse_cnt_r <= pw_last;
    end else if (rise_tick && raw_r) begin
      if (pulse_cnt_r == 8'h00) raw_r <= 1'b0;
      else pulse_cnt_r <= pulse_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else begin
      out_r <= raw_r ^ output_invert_r;
    end
  end
  assign osc_out = out_r;

  //**********************************************************************
  // overflow flag: set wins over a clearing write
  //**********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (accumulator_carry) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end
  assign overflow_irq_flag = flag_r;

  //**********************************************************************
  // read port
  //**********************************************************************
  // multi-byte accumulator reads are not latched together, so bytes may tear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        nco_pkg::OFF_CTRL: rdata_r <= {osc_enable_r, 1'b0, out_r, output_invert_r,
                                       3'b000, pulse_frequency_select_r};
        nco_pkg::OFF_CLKSEL: rdata_r <= {pulse_width_select_r, 2'b00, input_clock_select_r};
        nco_pkg::OFF_ACC_LO: rdata_r <= phase_accumulator_r[7:0];
        nco_pkg::OFF_ACC_HI: rdata_r <= phase_accumulator_r[15:8];
        nco_pkg::OFF_ACC_UP: rdata_r <= {4'h0, phase_accumulator_r[19:16]};
        nco_pkg::OFF_INC_LO: rdata_r <= inc_lo_r;
        nco_pkg::OFF_INC_HI: rdata_r <= inc_hi_r;
        nco_pkg::OFF_INC_UP: rdata_r <= inc_up_r;
        nco_pkg::OFF_FLAG: rdata_r <= {7'h00, flag_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  //**********************************************************************
  // checks
  //**********************************************************************
  chk_disabled_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !osc_enable_r && !acc_wr |=> $stable(phase_accumulator_r))
    else $error("accumulator moved while disabled");
  chk_status_level: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == nco_pkg::OFF_CTRL |=> rdata[nco_pkg::CTRL_OUT] == $past(out_r))
    else $error("status bit differs from output");
  chk_out_invert: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 osc_out == ($past(raw_r) ^ $past(output_invert_r)))
    else $error("output polarity wrong");
  chk_fdc_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    accumulator_carry && !pulse_frequency_select_r |=> raw_r != $past(raw_r))
    else $error("toggle mode missed overflow");
  chk_pulse_start: assert property (@(posedge clk) disable iff (!rst_n)
    accumulator_carry && pulse_frequency_select_r |=> raw_r ##1 osc_out == !output_invert_r)
    else $error("pulse not started");
  chk_pulse_single: assert property (@(posedge clk) disable iff (!rst_n)
    osc_enable_r && pulse_frequency_select_r && raw_r && pulse_cnt_r == 8'h00 && rise_tick
    && !accumulator_carry |=> !raw_r)
    else $error("pulse too long");
  chk_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == nco_pkg::OFF_ACC_UP |=> rdata[7:4] == 4'h0)
    else $error("upper accumulator bits not zero");
  chk_irq_set: assert property (@(posedge clk) disable iff (!rst_n)
    accumulator_carry |=> overflow_irq_flag ##1 (overflow_irq_flag || $past(flag_clr)))
    else $error("overflow flag not held");
  chk_acc_add: assert property (@(posedge clk) disable iff (!rst_n)
    osc_enable_r && rise_tick && !acc_wr |=> phase_accumulator_r == $past(sum[nco_pkg::ACC_W-1:0]))
    else $error("accumulator sum wrong");
  chk_increment_buffer_load: assert property (@(posedge clk) disable iff (!rst_n)
    !osc_enable_r && wr_ilo && !wr_ctrl ##1 !wr_ctrl |=> increment_buffer_r == $past(increment_value))
    else $error("increment buffer not loaded");
  chk_increment_buffer_run: assert property (@(posedge clk) disable iff (!rst_n)
    osc_enable_r && load_pending_r && fall_tick |=> increment_buffer_r == $past(increment_value))
    else $error("increment buffer missed falling tick");
  chk_increment_buffer_wait: assert property (@(posedge clk) disable iff (!rst_n)
    osc_enable_r && !(load_pending_r && fall_tick) |=> $stable(increment_buffer_r))
    else $error("increment buffer loaded early");
  chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    flag_clr && !accumulator_carry |=> !overflow_irq_flag)
    else $error("overflow flag not cleared");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    overflow_irq_flag && !flag_clr |=> overflow_irq_flag)
    else $error("overflow flag dropped");
  chk_disabled_low: assert property (@(posedge clk) disable iff (!rst_n)
    !osc_enable_r |=> !raw_r)
    else $error("output active while disabled");
  chk_ctrl_zero: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == nco_pkg::OFF_CTRL
    |=> (rdata & ~nco_pkg::CTRL_WMASK & ~(8'h01 << nco_pkg::CTRL_OUT)) == 8'h00)
    else $error("unimplemented control bits not zero");
  chk_clksel_zero: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.rd && bus_req.addr == nco_pkg::OFF_CLKSEL |=> (rdata & ~nco_pkg::CLKSEL_WMASK) == 8'h00)
    else $error("unimplemented clock select bits not zero");
  chk_fdc_steady: assert property (@(posedge clk) disable iff (!rst_n)
    osc_enable_r && !pulse_frequency_select_r && !accumulator_carry |=> $stable(raw_r))
    else $error("toggle mode output moved without overflow");
  chk_pulse_hold: assert property (@(posedge clk) disable iff (!rst_n)
    osc_enable_r && pulse_frequency_select_r && raw_r && pulse_cnt_r != 8'h00 |=> raw_r)
    else $error("pulse ended early");
  chk_reserved_idle: assert property (@(posedge clk) disable iff (!rst_n)
    input_clock_select_r == nco_pkg::NCO_CK_RSV6 || input_clock_select_r == nco_pkg::NCO_CK_RSV7
    |-> !rise_tick)
    else $error("reserved clock source ticked");

endmodule // nco_core

// file: verilog/nco_pkg.sv
// package: register map, field layout, reset values and bus carrier of the oscillator
//**********************************************************************
// What this block does
// - oscillator runs only while enable bit is set; clearing it holds the accumulator and resets the output logic
// - read-only status bit shows present output level
// - polarity bit inverts the output as the final stage
// - mode bit one selects pulse mode, zero selects toggle mode
// - pulse width is two to the field value input clock periods
// - pulse width field matters only in pulse mode
// - clock select field picks system, fast oscillator or logic cell outputs
// - accumulator is three bytes; upper byte top four bits read zero
// - accumulator runs in input clock time; no atomic multi-byte read
// - increment is upper, high and low bytes concatenated
// - increment buffer loads on next falling input edge after low byte write; while stopped it loads at once
// - unimplemented control and clock-select bits ignore writes, read zero
// - every register resets to zero except increment low bit zero
// - each rising input edge adds buffered increment; carry out is overflow
// - toggle mode flips the output on every overflow
// - pulse mode goes active on the rising edge after overflow
// - every overflow sets a sticky flag that software clears
//**********************************************************************
package nco_pkg;

  //**********************************************************************
  // register map
  //**********************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CLKSEL = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_ACC_LO = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_ACC_HI = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_ACC_UP = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_INC_LO = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_INC_HI = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_INC_UP = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_FLAG = 4'h8;

  //**********************************************************************
  // field positions and masks
  //**********************************************************************
  localparam int CTRL_EN = 7;
  localparam int CTRL_OUT = 5;
  localparam int CTRL_POL = 4;
  localparam int CTRL_PFM = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h91;
  localparam logic [7:0] CLKSEL_WMASK = 8'hE7;
  localparam logic [7:0] UP_MASK = 8'h0F;
  localparam int PWS_LSB = 5;
  localparam int CKS_LSB = 0;
  localparam int FLAG_BIT = 0;

  //**********************************************************************
  // widths, reset values and clock sources
  //**********************************************************************
  localparam int ACC_W = 20;
  localparam logic [ACC_W-1:0] ACC_RST = 20'h00000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] INC_LO_RST = 8'h01;
  localparam logic [ACC_W-1:0] INCREMENT_BUFFER_RST = 20'h00001;
  localparam logic [7:0] PW_ONE = 8'h01;

  typedef enum logic [2:0] {
    NCO_CK_SYS = 3'b000,
    NCO_CK_FAST = 3'b001,
    NCO_CK_LC1 = 3'b010,
    NCO_CK_LC2 = 3'b011,
    NCO_CK_LC3 = 3'b100,
    NCO_CK_LC4 = 3'b101,
    NCO_CK_RSV6 = 3'b110,
    NCO_CK_RSV7 = 3'b111
  } nco_cksel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } nco_bus_req_t;

endpackage

// file: testbench/nco_periph_model.sv
// file: neighbour peripherals that feed clock sources and watch the oscillator output
`timescale 1ns/1ps
module nco_periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_out,
  input wire logic count_en,
  output logic internal_fast_oscillator,
  output logic logic_cell_one_output,
  output logic logic_cell_two_output,
  output logic logic_cell_three_output,
  output logic logic_cell_four_output,
  output logic [15:0] edge_count
);
  //**********************************************************************
  // clock sources
  //**********************************************************************
  logic [4:0] div_r;
  logic last_r;
  // binary divider taps keep every source rate an exact power of two, so counts are exact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end
  assign internal_fast_oscillator = div_r[0];
  assign logic_cell_one_output = div_r[1];
  assign logic_cell_two_output = div_r[2];
  assign logic_cell_three_output = div_r[3];
  assign logic_cell_four_output = div_r[4];
  //**********************************************************************
  // output consumer: counts level changes inside a window
  //**********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= 1'b0;
      edge_count <= 16'h0000;
    end else begin
      last_r <= osc_out;
      if (!count_en) begin
        edge_count <= 16'h0000;
      end else if (osc_out !== last_r) begin
        edge_count <= edge_count + 16'h0001;
      end
    end
  end
endmodule // nco_periph_model

// file: testbench/testbench.sv
// file: self-checking bench of the oscillator core
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, got, exp); end end
module testbench;
  logic clk;
  logic rst_n;
  nco_pkg::nco_bus_req_t bus_req;
  logic [7:0] rdata;
  logic fast, lc1, lc2, lc3, lc4, osc_out, flag, count_en;
  logic [15:0] edge_count;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  nco_core i_nco_core (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .internal_fast_oscillator(fast), .logic_cell_one_output(lc1), .logic_cell_two_output(lc2),
    .logic_cell_three_output(lc3), .logic_cell_four_output(lc4), .osc_out(osc_out),
    .overflow_irq_flag(flag));
  nco_periph_model i_nco_periph_model (.clk(clk), .rst_n(rst_n), .osc_out(osc_out), .count_en(count_en),
    .internal_fast_oscillator(fast), .logic_cell_one_output(lc1), .logic_cell_two_output(lc2),
    .logic_cell_three_output(lc3), .logic_cell_four_output(lc4), .edge_count(edge_count));

  //**********************************************************************
  // clock, timeout and verdict
  //**********************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // every scenario is bounded, so this ceiling only trips on a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  //**********************************************************************
  // bus and measurement helpers
  //**********************************************************************
  task automatic wr(input logic [nco_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [nco_pkg::ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic window(input int n, output logic [15:0] c);
    @(posedge clk);
    count_en <= 1'b1;
    repeat (n) @(posedge clk);
    count_en <= 1'b0;
    #1 c = edge_count;
  endtask
  // increment written up, high, then low: the low byte arms the buffer load
  task automatic set_inc(input logic [7:0] up, input logic [7:0] hi, input logic [7:0] lo);
    wr(nco_pkg::OFF_INC_UP, up);
    wr(nco_pkg::OFF_INC_HI, hi);
    wr(nco_pkg::OFF_INC_LO, lo);
  endtask
  task automatic clear_acc();
    wr(nco_pkg::OFF_ACC_LO, 8'h00);
    wr(nco_pkg::OFF_ACC_HI, 8'h00);
    wr(nco_pkg::OFF_ACC_UP, 8'h00);
  endtask
  //**********************************************************************
  // scenarios
  //**********************************************************************
  task automatic t_reset();
    logic [7:0] exp_r [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    for (int a = 0; a < 10; a++) begin
      rd(4'(a), d);
      `CHK(d, exp_r[a])
    end
  endtask
  task automatic t_fields();
    logic [7:0] d;
    wr(nco_pkg::OFF_CTRL, 8'h6E);
    rd(nco_pkg::OFF_CTRL, d);
    `CHK(d, 8'h00)
    wr(nco_pkg::OFF_CLKSEL, 8'h18);
    rd(nco_pkg::OFF_CLKSEL, d);
    `CHK(d, 8'h00)
    wr(nco_pkg::OFF_ACC_UP, 8'hFF);
    wr(nco_pkg::OFF_ACC_LO, 8'h5A);
    wr(nco_pkg::OFF_ACC_HI, 8'hA5);
    rd(nco_pkg::OFF_ACC_UP, d);
    `CHK(d, 8'h0F)
    rd(nco_pkg::OFF_ACC_LO, d);
    `CHK(d, 8'h5A)
    rd(nco_pkg::OFF_ACC_HI, d);
    `CHK(d, 8'hA5)
    clear_acc();
  endtask
  // half-scale increment toggles every second tick of each source; the width field must not matter
  task automatic t_sources();
    logic [15:0] c;
    logic [7:0] a, b;
    set_inc(8'h08, 8'h00, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(nco_pkg::OFF_CLKSEL, 8'hE0 | 8'(s));
      wr(nco_pkg::OFF_CTRL, 8'h80);
      repeat (80) @(posedge clk);
      window(256, c);
      `CHK(c, (s <= 5) ? 16'(256 >> (s + 1)) : 16'h0000)
      wr(nco_pkg::OFF_CTRL, 8'h00);
    end
    repeat (4) @(posedge clk);
    #1 `CHK(osc_out, 1'b0)
    rd(nco_pkg::OFF_ACC_UP, a);
    window(40, c);
    `CHK(c, 16'h0000)
    rd(nco_pkg::OFF_ACC_UP, b);
    `CHK(b, a)
    `CHK(flag, 1'b1)
    rd(nco_pkg::OFF_FLAG, a);
    `CHK(a, 8'h01)
    wr(nco_pkg::OFF_FLAG, 8'h01);
    rd(nco_pkg::OFF_FLAG, a);
    `CHK(a, 8'h01)
    wr(nco_pkg::OFF_FLAG, 8'h00);
    #1 `CHK(flag, 1'b0)
  endtask
  task automatic t_polarity();
    logic [7:0] d;
    wr(nco_pkg::OFF_CTRL, 8'h10);
    repeat (4) @(posedge clk);
    #1 `CHK(osc_out, 1'b1)
    rd(nco_pkg::OFF_CTRL, d);
    `CHK(d[5], 1'b1)
    `CHK(d & 8'hDF, 8'h10)
    wr(nco_pkg::OFF_CTRL, 8'h00);
  endtask
  // increment 0x01000 overflows once per 256 system ticks, longer than the widest pulse
  task automatic t_pulse();
    logic [15:0] c;
    int n;
    set_inc(8'h00, 8'h10, 8'h00);
    for (int code = 0; code < 8; code++) begin
      wr(nco_pkg::OFF_CLKSEL, 8'(code << 5));
      clear_acc();
      wr(nco_pkg::OFF_CTRL, 8'h81);
      n = 0;
      while (osc_out !== 1'b1 && n < 400) begin
        @(posedge clk);
        #1 n++;
      end
      n = 0;
      while (osc_out === 1'b1 && n < 300) begin
        @(posedge clk);
        #1 n++;
      end
      `CHK(n, 1 << code)
      if (code == 0) begin
        window(512, c);
        `CHK(c, 16'h0004)
      end
      wr(nco_pkg::OFF_CTRL, 8'h00);
    end
  endtask
  task automatic t_buffer();
    logic [15:0] c;
    clear_acc();
    set_inc(8'h08, 8'h00, 8'h00);
    wr(nco_pkg::OFF_CLKSEL, 8'h03);
    wr(nco_pkg::OFF_CTRL, 8'h80);
    repeat (80) @(posedge clk);
    wr(nco_pkg::OFF_INC_UP, 8'h04);
    repeat (40) @(posedge clk);
    window(256, c);
    `CHK(c, 16'h0010)
    wr(nco_pkg::OFF_INC_LO, 8'h00);
    repeat (80) @(posedge clk);
    window(256, c);
    `CHK(c, 16'h0008)
    wr(nco_pkg::OFF_CTRL, 8'h00);
  endtask
  //**********************************************************************
  // main sequence
  //**********************************************************************
  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    count_en = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_sources();
    t_polarity();
    t_pulse();
    t_buffer();
    conclude();
  end
endmodule // testbench
